// ---- design/sebfe_pkg.sv ----
// shared constants for the two-wire eeprom front end and its controller
package sebfe_pkg;
    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS         = 10;
    localparam int unsigned PROGRAM_CYCLE_TIME_NS = 5000000;
    // longest time, so integer division rounds down
    localparam int unsigned SEBFE_PROG_CYCLES     = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned PROG_CNT_W            = 24;
    localparam int unsigned SCL_PERIOD_NS         = 2500;
    localparam int unsigned SCL_QUARTER_CYCLES    = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
    localparam int unsigned QCNT_W                = 16;

    // ------------------------------------------------------------------
    // device addressing and array shape
    // ------------------------------------------------------------------
    localparam logic [3:0]  DEV_TYPE_CODE = 4'hA;
    localparam int unsigned PAGE_BYTES    = 16;
    localparam int unsigned ARRAY_BYTES   = 256;
    localparam logic [3:0]  LAST_BIT_CNT  = 4'h8;
    localparam logic [3:0]  ACK_BIT_CNT   = 4'h9;

    // ------------------------------------------------------------------
    // controller register map (apb, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_CMD       = 8'h00;
    localparam logic [7:0]  REG_RXDATA    = 8'h04;
    localparam logic [7:0]  REG_STATUS    = 8'h08;
    localparam int unsigned CMD_OP_LSB    = 8;
    localparam int unsigned CMD_NACK_BIT  = 11;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_NACK_BIT = 1;
    localparam logic [2:0]  OP_START      = 3'h1;
    localparam logic [2:0]  OP_STOP       = 3'h2;
    localparam logic [2:0]  OP_WRITE      = 3'h3;
    localparam logic [2:0]  OP_READ       = 3'h4;
endpackage : sebfe_pkg

// ---- design/sebfe_if.sv ----
// two-wire link between eeprom front end and bus controller
`timescale 1ns/10ps
`default_nettype none
interface sebfe_if;
    logic scl;
    logic dev_sda_oe;
    logic host_sda_oe;
    logic sda_line;

    // external pull-up: line is low whenever any end pulls it down
    assign sda_line = ~(dev_sda_oe | host_sda_oe);

    modport dev  (input scl, input sda_line, output dev_sda_oe);
    modport host (output scl, output host_sda_oe, input sda_line);
endinterface : sebfe_if
`default_nettype wire

// ---- design/sebfe_dev.sv ----
// two-wire serial eeprom front end with 256 x 8 array
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - sample on scl rise, launch after fall
// - data line only pulled low or released
// - write protect high blocks all programming
// - sixteen pages of sixteen bytes, 8-bit address
// - data changes only while scl low
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - stop after write programs, then standby
// - acknowledge each byte on ninth clock
// - standby after powerup, read stop, programming
// - first byte upper nibble must be type code
// - chip select bits match pins or standby
// - reduced pin variant ignores chip select bits
// - eighth address bit selects read or write
// - page writes up to sixteen, partial allowed
// - self-timed programming within five milliseconds
// - page write increments low four bits only
// - no acknowledge while programming runs
// - read counter increments, wraps to zero
// - new start abandons pending write
module sebfe_dev #(
    parameter int unsigned PROG_CYCLES         = sebfe_pkg::SEBFE_PROG_CYCLES,
    parameter bit          REDUCED_PIN_VARIANT = 1'b0
) (
    input  wire logic       CLK,
    input  wire logic       SRST,
    sebfe_if.dev            BUS,
    input  wire logic [2:0] CHIP_SELECT_ADDRESS_PINS,
    input  wire logic       WP,
    output logic            STANDBY,
    output logic            PROG_BUSY
);
    import sebfe_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WORD,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } sebfe_dev_state_e;

    typedef struct packed {
        sebfe_dev_state_e  st;
        logic [5:0]        s1;      // {wp, cs[2:0], scl, sda} first stage
        logic [5:0]        s2;
        logic [1:0]        s3;      // previous {scl, sda} for edges
        logic [3:0]        cnt;     // scl rises in current byte
        logic [7:0]        sh;
        logic [7:0]        addr;
        logic [15:0][7:0]  pbuf;
        logic [15:0]       mask;
        logic              nack;
        logic              sda_oe;
        logic              busy;
        logic [PROG_CNT_W-1:0] tmr;
        logic [4:0]        cidx;
        logic              standby;
    } sebfe_dev_s;

    sebfe_dev_s r;
    sebfe_dev_s n;

    logic [7:0] mem [ARRAY_BYTES];
    logic       mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] rdat;

    logic       wp_s;
    logic [2:0] cs_s;
    logic       scl_s;
    logic       sda_s;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       addr_hit;

    // ------------------------------------------------------------------
    // bus event decode
    // ------------------------------------------------------------------
    // all edges seen on the second synchroniser stage against the third
    assign wp_s  = r.s2[5];
    assign cs_s  = r.s2[4:2];
    assign scl_s = r.s2[1];
    assign sda_s = r.s2[0];
    assign rise  = scl_s & ~r.s3[1];
    assign fall  = ~scl_s & r.s3[1];
    assign start = scl_s & r.s3[1] & r.s3[0] & ~sda_s;
    assign stop  = scl_s & r.s3[1] & ~r.s3[0] & sda_s;

    // type code, then pin match unless the reduced variant skips it
    assign addr_hit = (r.sh[7:4] == DEV_TYPE_CODE)
                    && (REDUCED_PIN_VARIANT
                        || (r.sh[3:1] == cs_s));

    assign rdat = mem[r.addr];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n      = r;
        mem_we = 1'b0;
        mem_wa = {r.addr[7:4], r.cidx[3:0]};
        mem_wd = r.pbuf[r.cidx[3:0]];
        n.s1   = {WP, CHIP_SELECT_ADDRESS_PINS, BUS.scl, BUS.sda_line};
        n.s2   = r.s1;
        n.s3   = r.s2[1:0];

        // self-timed programming needs no scl; one column per cycle
        if (r.busy) begin
            if (!r.cidx[4]) begin
                mem_we = r.mask[r.cidx[3:0]];
                n.cidx = r.cidx + 5'h01;
            end
            n.tmr = r.tmr - 1'b1;
            if (r.tmr == '0) begin
                n.busy = 1'b0;
                n.mask = '0;
            end
        end

        if (start) begin
            n.st     = ST_DEV;
            n.cnt    = '0;
            n.sda_oe = 1'b0;
            // an unfinished write is dropped, a running program is not
            if (!r.busy) begin
                n.mask = '0;
            end
        end else if (stop) begin
            n.sda_oe = 1'b0;
            n.st     = ST_IDLE;
            if (r.st == ST_WDATA && r.mask != '0 && !r.busy) begin
                n.busy = 1'b1;
                n.tmr  = PROG_CNT_W'(PROG_CYCLES - 1);
                n.cidx = '0;
            end
        end else if (r.st != ST_IDLE && r.st != ST_IGNORE) begin
            // sample on rise: write data shifts in, read takes master ack
            if (rise) begin
                n.cnt = r.cnt + 4'h1;
                if (r.cnt < LAST_BIT_CNT && r.st != ST_RDATA) begin
                    n.sh = {r.sh[6:0], sda_s};
                end
                if (r.cnt == LAST_BIT_CNT && r.st == ST_RDATA) begin
                    n.nack = sda_s;
                end
            end
            // launch on fall so the line only moves while scl is low
            if (fall) begin
                if (r.cnt == LAST_BIT_CNT) begin
                    if (r.st == ST_RDATA) begin
                        n.sda_oe = 1'b0;                    // release for master ack
                    end else begin
                        case (r.st)
                            ST_DEV: begin
                                if (addr_hit && !r.busy) begin
                                    n.sda_oe = 1'b1;
                                    n.nack   = 1'b0;
                                    n.st     = r.sh[0] ? ST_RDATA : ST_WORD;
                                end else begin
                                    n.st = ST_IGNORE;
                                end
                            end
                            ST_WORD: begin
                                n.addr   = r.sh;
                                n.sda_oe = 1'b1;
                                n.st     = ST_WDATA;
                            end
                            ST_WDATA: begin
                                n.pbuf[r.addr[3:0]] = r.sh;
                                // protected bytes are acked but never marked
                                n.mask[r.addr[3:0]] = r.mask[r.addr[3:0]] | ~wp_s;
                                n.addr[3:0] = r.addr[3:0] + 4'h1;
                                n.sda_oe    = 1'b1;
                            end
                            default: begin
                                n.st = ST_IGNORE;
                            end
                        endcase
                    end
                end else if (r.cnt == ACK_BIT_CNT) begin
                    n.cnt    = '0;
                    n.sda_oe = 1'b0;
                    if (r.st == ST_RDATA) begin
                        if (r.nack) begin
                            n.st = ST_IGNORE;
                        end else begin
                            n.sh     = rdat;
                            n.addr   = r.addr + 8'h01;
                            n.sda_oe = ~rdat[7];
                        end
                    end
                end else if (r.st == ST_RDATA && r.cnt != '0) begin
                    n.sh     = {r.sh[6:0], 1'b1};
                    n.sda_oe = ~r.sh[6];
                end
            end
        end

        n.standby = (n.st == ST_IDLE || n.st == ST_IGNORE) && !n.busy;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // power-up behaves as reset: standby, nothing pending
    always_ff @(posedge CLK) begin
        if (SRST) begin
            r         <= '0;
            r.standby <= 1'b1;
            // idle bus levels, so no false edge follows reset
            r.s1[1:0] <= 2'h3;
            r.s2[1:0] <= 2'h3;
            r.s3      <= 2'h3;
        end else begin
            r <= n;
        end
    end

    // array write port, fed one column per cycle while programming
    always_ff @(posedge CLK) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign BUS.dev_sda_oe = r.sda_oe;
    assign STANDBY        = r.standby;
    assign PROG_BUSY      = r.busy;
endmodule : sebfe_dev
`default_nettype wire

// ---- design/sebfe_host.sv ----
// two-wire bus controller with apb command registers
`timescale 1ns/10ps
`default_nettype none
module sebfe_host #(
    parameter int unsigned QUARTER_CYCLES = sebfe_pkg::SCL_QUARTER_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    sebfe_if.host            BUS
);
    import sebfe_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              run;
        logic [2:0]        op;
        logic [1:0]        ph;      // quarter of the scl period
        logic [QCNT_W-1:0] qcnt;
        logic [3:0]        bitn;
        logic [8:0]        sh;      // 8 bits plus ack slot
        logic [8:0]        rx;
        logic              scl;
        logic              sda_oe;
        logic [7:0]        rxdata;
        logic              nack;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
        logic              s1;
        logic              s2;
    } sebfe_host_s;

    sebfe_host_s r;
    sebfe_host_s n;
    logic        setup;
    logic        access;
    logic [2:0]  wop;

    // register read mux, unmapped reads give zero
    function automatic logic [31:0] rd_word(input logic [7:0] a, input sebfe_host_s s);
        rd_word = '0;
        if (a == REG_RXDATA) begin
            rd_word[7:0] = s.rxdata;
        end else if (a == REG_STATUS) begin
            rd_word[STAT_BUSY_BIT] = s.run;
            rd_word[STAT_NACK_BIT] = s.nack;
        end
    endfunction : rd_word

    assign setup  = PSEL & ~PENABLE;
    assign access = PSEL & PENABLE & r.pready;
    assign wop    = PWDATA[CMD_OP_LSB +: 3];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n         = r;
        n.s1      = BUS.sda_line;
        n.s2      = r.s1;
        // one wait-free access: answer is registered during setup
        n.pready  = setup;
        n.pslverr = setup && PADDR != REG_CMD && PADDR != REG_RXDATA
                    && PADDR != REG_STATUS;
        n.prdata  = (setup && !PWRITE) ? rd_word(PADDR, r) : '0;

        // a command written while busy is dropped
        if (access && PWRITE && PADDR == REG_CMD && !r.run
            && wop >= OP_START && wop <= OP_READ) begin
            n.run  = 1'b1;
            n.op   = wop;
            n.ph   = '0;
            n.qcnt = '0;
            n.bitn = '0;
            n.sh   = (wop == OP_READ) ? {8'hFF, PWDATA[CMD_NACK_BIT]}
                                      : {PWDATA[7:0], 1'b1};
        end

        // quarter-period engine; scl made here by division
        if (r.run) begin
            if (r.qcnt == QCNT_W'(QUARTER_CYCLES - 1)) begin
                n.qcnt = '0;
                n.ph   = r.ph + 2'h1;
                case (r.ph)
                    2'h0: begin
                        if (r.op == OP_START) begin
                            n.sda_oe = 1'b0;
                        end else if (r.op == OP_STOP) begin
                            n.sda_oe = 1'b1;
                        end else begin
                            n.sda_oe = ~r.sh[8];
                        end
                    end
                    2'h1: begin
                        n.scl = 1'b1;
                    end
                    2'h2: begin
                        if (r.op == OP_START) begin
                            n.sda_oe = 1'b1;
                        end else if (r.op == OP_STOP) begin
                            n.sda_oe = 1'b0;
                        end else begin
                            n.rx = {r.rx[7:0], r.s2};
                        end
                    end
                    default: begin
                        if (r.op != OP_STOP) begin
                            n.scl = 1'b0;
                        end
                        n.sh   = {r.sh[7:0], 1'b1};
                        n.bitn = r.bitn + 4'h1;
                        if (r.op == OP_START || r.op == OP_STOP
                            || r.bitn == LAST_BIT_CNT) begin
                            n.run = 1'b0;
                            if (r.op == OP_WRITE || r.op == OP_READ) begin
                                n.rxdata = r.rx[8:1];
                                n.nack   = r.rx[0];
                                n.sda_oe = 1'b0;
                            end
                        end
                    end
                endcase
            end else begin
                n.qcnt = r.qcnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            r     <= '0;
            r.scl <= 1'b1;                                  // idle bus: scl high
            r.s1  <= 1'b1;
            r.s2  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign PRDATA          = r.prdata;
    assign PREADY          = r.pready;
    assign PSLVERR         = r.pslverr;
    assign BUS.scl         = r.scl;
    assign BUS.host_sda_oe = r.sda_oe;
endmodule : sebfe_host
`default_nettype wire

// ---- tb/sebfe_monitor.sv ----
// concurrent checks on the two-wire link between controller and eeprom
`timescale 1ns/10ps
`default_nettype none
module sebfe_monitor #(
    parameter int unsigned PROG_CYCLES = 200
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic scl,
    input wire logic dev_sda_oe,
    input wire logic host_sda_oe,
    input wire logic sda_line,
    input wire logic PROG_BUSY,
    input wire logic STANDBY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [23:0] busy_cnt_reg;
    logic [7:0]  stop_age_reg;
    logic        sda_prev_reg;

    // busy length, and age of the last stop seen on the wire
    always_ff @(posedge CLK) begin
        sda_prev_reg <= sda_line;
        if (SRST) begin
            busy_cnt_reg <= 24'h0;
            stop_age_reg <= 8'hFF;
        end else begin
            busy_cnt_reg <= PROG_BUSY ? busy_cnt_reg + 24'h1 : 24'h0;
            if (scl && sda_line && !sda_prev_reg) stop_age_reg <= 8'h00;
            else if (stop_age_reg != 8'hFF) stop_age_reg <= stop_age_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    reset_idle_a: assert property ($fell(SRST) |-> !dev_sda_oe && STANDBY && !PROG_BUSY)
        else $error("front end not idle after reset");
    dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
        else $error("device data moved while clock high");
    busy_quiet_a: assert property (PROG_BUSY |-> !dev_sda_oe)
        else $error("device drove data while programming");
    busy_len_a: assert property ($fell(PROG_BUSY) |->
        busy_cnt_reg >= PROG_CYCLES - 1 && busy_cnt_reg <= PROG_CYCLES + 1)
        else $error("programming time wrong");
    busy_bound_a: assert property (PROG_BUSY |-> busy_cnt_reg <= PROG_CYCLES + 1)
        else $error("programming overran");
    prog_stop_a: assert property ($rose(PROG_BUSY) |-> stop_age_reg < 8'h10)
        else $error("programming began without stop");
    busy_sb_a: assert property (PROG_BUSY |-> !STANDBY)
        else $error("standby while programming");
    drive_sb_a: assert property (dev_sda_oe |-> !STANDBY)
        else $error("standby while driving data");

    // main scenarios reached
    cover property ($rose(PROG_BUSY));
    cover property ($rose(dev_sda_oe) && !host_sda_oe);
    cover property (scl && $fell(sda_line));
endmodule : sebfe_monitor
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench joining the bus controller and the eeprom front end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sebfe_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam int unsigned PROG = 2000;  // long enough to poll while busy
    localparam int unsigned QC   = 10;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr;
    logic        wp, standby, prog_busy, standby_rp;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [2:0]  cs_pins;
    logic [7:0]  mem [256];
    int          err_total, n_checks;

    sebfe_if i_sebfe_if ();
    sebfe_dev #(.PROG_CYCLES(PROG), .REDUCED_PIN_VARIANT(1'b0)) i_sebfe_dev (
        .CLK(clk), .SRST(srst), .BUS(i_sebfe_if.dev), .CHIP_SELECT_ADDRESS_PINS(cs_pins),
        .WP(wp), .STANDBY(standby), .PROG_BUSY(prog_busy));
    sebfe_host #(.QUARTER_CYCLES(QC)) i_sebfe_host (
        .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BUS(i_sebfe_if.host));
    // reduced pin listener: sees the shared line, its own pulls never reach it
    sebfe_if i_sebfe_if_rp ();
    assign i_sebfe_if_rp.scl         = i_sebfe_if.scl;
    assign i_sebfe_if_rp.host_sda_oe = ~i_sebfe_if.sda_line;
    sebfe_dev #(.PROG_CYCLES(PROG), .REDUCED_PIN_VARIANT(1'b1)) i_sebfe_dev_rp (
        .CLK(clk), .SRST(srst), .BUS(i_sebfe_if_rp.dev), .CHIP_SELECT_ADDRESS_PINS(~cs_pins),
        .WP(wp), .STANDBY(standby_rp), .PROG_BUSY());
    sebfe_monitor #(.PROG_CYCLES(PROG)) i_sebfe_monitor (
        .CLK(clk), .SRST(srst), .scl(i_sebfe_if.scl), .dev_sda_oe(i_sebfe_if.dev_sda_oe),
        .host_sda_oe(i_sebfe_if.host_sda_oe), .sda_line(i_sebfe_if.sda_line),
        .PROG_BUSY(prog_busy), .STANDBY(standby));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [7:0] dadr(input logic rw);
        return {DEV_TYPE_CODE, cs_pins, rw};
    endfunction : dadr

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk_byte

    task automatic final_report();
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // one transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready seen high ends this wait; the watchdog ends it if pready never comes
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one controller command, polled until the controller is free
    task automatic op(input logic [2:0] o, input logic [7:0] b, input logic nk,
                      output logic [7:0] rx, output logic ak);
        logic [31:0] q;
        logic        e;
        apb(1'b1, REG_CMD, {20'h0, nk, o, b}, q, e);
        do begin
            apb(1'b0, REG_STATUS, 32'h0, q, e);
        end while (q[STAT_BUSY_BIT] !== 1'b0);
        ak = ~q[STAT_NACK_BIT];
        apb(1'b0, REG_RXDATA, 32'h0, q, e);
        rx = q[7:0];
    endtask : op

    task automatic cond(input logic [2:0] o);
        logic [7:0] rx;
        logic       ak;
        op(o, 8'h00, 1'b0, rx, ak);
    endtask : cond

    task automatic sb(input logic [7:0] b, input logic ea);
        logic [7:0] rx;
        logic       ak;
        op(OP_WRITE, b, 1'b0, rx, ak);
        chk_bit("ack", ea, ak);
    endtask : sb

    task automatic rb(input logic nk, input logic [7:0] e);
        logic [7:0] rx;
        logic       ak;
        op(OP_READ, 8'h00, nk, rx, ak);
        chk_byte("read data", e, rx);
    endtask : rb

    // address the device until it answers; busy says whether the first try must fail
    task automatic poll(input logic busy);
        logic [7:0] rx;
        logic       ak;
        int         t;
        t = 0;
        do begin
            cond(OP_START);
            op(OP_WRITE, dadr(1'b0), 1'b0, rx, ak);
            cond(OP_STOP);
            t++;
            if (t == 1) chk_bit("first poll ack", ~busy, ak);
        end while (ak !== 1'b1 && t < 20);
        chk_bit("poll ack", 1'b1, ak);
    endtask : poll

    // random data from address a; model skips the array when protected
    task automatic write_run(input logic [7:0] a, input int n);
        logic [7:0] d;
        cond(OP_START);
        sb(dadr(1'b0), 1'b1);
        sb(a, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = 8'(xs());
            sb(d, 1'b1);
            if (wp !== 1'b1) mem[{a[7:4], a[3:0] + 4'(i)}] = d;
        end
        cond(OP_STOP);
    endtask : write_run

    // dummy write, repeated start, then sequential read ending in a nack
    task automatic read_run(input logic [7:0] a, input int n);
        cond(OP_START);
        sb(dadr(1'b0), 1'b1);
        sb(a, 1'b1);
        cond(OP_START);
        sb(dadr(1'b1), 1'b1);
        for (int i = 0; i < n; i++) rb(i == n - 1, mem[8'(a + i)]);
        cond(OP_STOP);
    endtask : read_run

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // whole run is about 36000 cycles; allow nearly three times that
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        final_report();
    end

    initial begin
        logic [31:0] q;
        logic        e;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wp = 1'b0;
        cs_pins = 3'h0;
        err_total = 0;
        n_checks = 0;
        seed = 32'hB3CF792B;
        repeat (5) @(posedge clk);
        cs_pins <= 3'(xs());
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit("standby", 1'b1, standby);
        // page write of eighteen bytes from column 14, two more than the page holds
        write_run(8'hFE, 18);
        poll(1'b1);
        read_run(8'hF0, 16);
        write_run(8'h00, 1);
        poll(1'b1);
        chk_bit("standby", 1'b1, standby);
        // protected write must leave the array and the busy state alone
        wp <= 1'b1;
        write_run(8'h00, 1);
        poll(1'b0);
        wp <= 1'b0;
        read_run(8'hFF, 2);
        // every type code, then every chip select value
        for (int t = 0; t < 16; t++) begin
            cond(OP_START);
            sb({4'(t), cs_pins, 1'b0}, 4'(t) == DEV_TYPE_CODE);
            cond(OP_STOP);
        end
        for (int c = 0; c < 8; c++) begin
            cond(OP_START);
            sb({DEV_TYPE_CODE, 3'(c), 1'b0}, 3'(c) == cs_pins);
            chk_bit("standby", 3'(c) != cs_pins, standby);
            chk_bit("reduced pin standby", 1'b0, standby_rp);
            cond(OP_STOP);
        end
        apb(1'b0, 8'h0C, 32'h0, q, e);
        chk_bit("pslverr", 1'b1, e);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
